// ### hw/sctrim_pkg.sv
package sctrim_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int SLOW_TRIM_W = 6;
    localparam int FAST_TRIM_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_SYNC_STARTUP = 8'h38;
    localparam logic [7:0] OFS_SLOW_CFG = 8'h4B;
    localparam logic [7:0] OFS_FAST_TRIM = 8'h4D;

    // Reset values and slow trim centre code
    localparam logic [15:0] RST_SYNC_STARTUP = 16'h0000;
    localparam logic [15:0] RST_SLOW_CFG = 16'h2612;
    localparam logic [15:0] RST_FAST_TRIM = 16'h0098;
    localparam logic [5:0] RST_SLOW_TRIM = 6'h12;
    localparam logic [7:0] RST_FAST_TRIM_CODE = 8'h98;
    localparam logic [5:0] SLOW_TRIM_CENTRE = 6'h22;

    // Field positions in the slow clock register
    localparam int BIT_BYPASS = 8;
    localparam int BIT_CLK_EN = 7;
    localparam int BIT_SLOW_RSVD = 6;
    localparam int SLOW_RSVD_LSB = 9;
    localparam int SLOW_RSVD_MSB = 15;
    localparam logic [6:0] SLOW_RSVD_VAL = 7'h13;

    // Startup word values
    localparam logic [15:0] SYNC_STARTUP_PIN = 16'h4000;
    localparam logic [15:0] SYNC_STARTUP_INT = 16'h0000;

    // Sample trigger selection codes
    localparam logic [1:0] TRIG_INTERNAL = 2'h0;
    localparam logic [1:0] TRIG_PIN_ZERO = 2'h1;
    localparam logic [1:0] TRIG_PIN_ONE = 2'h2;
    localparam logic [1:0] TRIG_RESERVED = 2'h3;

    // Pin one {output enable, input enable} for input use
    localparam logic [1:0] PIN_ONE_AS_INPUT = 2'h1;

    typedef struct packed {
        logic bypass;
        logic enable;
        logic [SLOW_TRIM_W-1:0] slow_trim;
        logic [FAST_TRIM_W-1:0] fast_trim;
    } sctrim_cfg_s;

endpackage

// ### hw/sctrim_trig.sv
module sctrim_trig (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [1:0] i_sel,
    input wire logic i_rate_tick,
    input wire logic i_pin_zero,
    input wire logic i_pin_one,
    output logic o_trigger
);
    logic pin_zero_r, pin_zero_nxt;
    logic pin_one_r, pin_one_nxt;
    logic trig_r, trig_nxt;

    always_comb begin
        pin_zero_nxt = i_pin_zero;
        pin_one_nxt = i_pin_one;
        unique case (i_sel)
            sctrim_pkg::TRIG_INTERNAL: trig_nxt = i_rate_tick;
            sctrim_pkg::TRIG_PIN_ZERO: trig_nxt = i_pin_zero & ~pin_zero_r;
            sctrim_pkg::TRIG_PIN_ONE: trig_nxt = i_pin_one & ~pin_one_r;
            sctrim_pkg::TRIG_RESERVED: trig_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pin_zero_r <= 1'b0;
            pin_one_r <= 1'b0;
            trig_r <= 1'b0;
        end else begin
            pin_zero_r <= pin_zero_nxt;
            pin_one_r <= pin_one_nxt;
            trig_r <= trig_nxt;
        end
    end

    assign o_trigger = trig_r;

endmodule // sctrim_trig

// ### hw/sctrim_top.sv
// Functional notes
// - Bypass bit 8 set takes slow sample clock from pin one.
// - Enable bit 7 runs the sample clock; resets stopped.
// - Six-bit slow trim, about 0.6 kHz per step, larger is slower.
// - Slow trim zero is fastest, all-ones slowest, resets to 0x12.
// - Eight-bit fast trim, about 109 kHz per step, larger is faster.
// - Fast trim zero is slowest, all-ones fastest, resets to 0x98.
// - Trigger select: internal clock, pin zero edge, pin one edge, reserved.
module sctrim_top (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [sctrim_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [sctrim_pkg::DATA_W-1:0] i_reg_wdata,
    output logic [sctrim_pkg::DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [1:0] i_sample_trigger_select,
    input wire logic i_pin_one_output_enable,
    input wire logic i_pin_one_input_enable,
    input wire logic i_aux_pin_zero,
    input wire logic i_aux_pin_one,
    input wire logic i_slow_osc,
    input wire logic i_rate_tick,
    output sctrim_pkg::sctrim_cfg_s o_cfg,
    output logic o_sample_clk,
    output logic o_sample_trigger,
    output logic o_startup_word_ok,
    output logic o_bypass_pin_ready
);
    logic [15:0] sync_word_r, sync_word_nxt;
    logic [15:0] slow_cfg_r, slow_cfg_nxt;
    logic [15:0] fast_cfg_r, fast_cfg_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic sclk_r, sclk_nxt;
    logic word_ok_r, word_ok_nxt;
    logic pin_ready_r, pin_ready_nxt;
    logic gated_tick;
    logic pin_trig_sel;

    // Register writes and reads
    always_comb begin
        sync_word_nxt = sync_word_r;
        slow_cfg_nxt = slow_cfg_r;
        fast_cfg_nxt = fast_cfg_r;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                sctrim_pkg::OFS_SYNC_STARTUP: sync_word_nxt = i_reg_wdata;
                sctrim_pkg::OFS_SLOW_CFG: slow_cfg_nxt = i_reg_wdata;
                sctrim_pkg::OFS_FAST_TRIM: fast_cfg_nxt = i_reg_wdata;
                default: sync_word_nxt = sync_word_r;
            endcase
        end
        rvalid_nxt = i_reg_rd;
        rdata_nxt = 16'h0000;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                sctrim_pkg::OFS_SYNC_STARTUP: rdata_nxt = sync_word_r;
                sctrim_pkg::OFS_SLOW_CFG: rdata_nxt = slow_cfg_r;
                sctrim_pkg::OFS_FAST_TRIM: rdata_nxt = fast_cfg_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    // Sample clock source, pin trigger select decode and status
    always_comb begin
        if (!slow_cfg_r[sctrim_pkg::BIT_CLK_EN]) begin
            sclk_nxt = 1'b0;
        end else if (slow_cfg_r[sctrim_pkg::BIT_BYPASS]) begin
            sclk_nxt = i_aux_pin_one;
        end else begin
            sclk_nxt = i_slow_osc;
        end
        pin_trig_sel = (i_sample_trigger_select == sctrim_pkg::TRIG_PIN_ZERO) ||
            (i_sample_trigger_select == sctrim_pkg::TRIG_PIN_ONE);
        word_ok_nxt = pin_trig_sel ? (sync_word_r == sctrim_pkg::SYNC_STARTUP_PIN) :
            (sync_word_r == sctrim_pkg::SYNC_STARTUP_INT);
        pin_ready_nxt = slow_cfg_r[sctrim_pkg::BIT_BYPASS] &&
            ({i_pin_one_output_enable, i_pin_one_input_enable} ==
            sctrim_pkg::PIN_ONE_AS_INPUT);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sync_word_r <= sctrim_pkg::RST_SYNC_STARTUP;
            slow_cfg_r <= sctrim_pkg::RST_SLOW_CFG;
            fast_cfg_r <= sctrim_pkg::RST_FAST_TRIM;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
            sclk_r <= 1'b0;
            word_ok_r <= 1'b0;
            pin_ready_r <= 1'b0;
        end else begin
            sync_word_r <= sync_word_nxt;
            slow_cfg_r <= slow_cfg_nxt;
            fast_cfg_r <= fast_cfg_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            sclk_r <= sclk_nxt;
            word_ok_r <= word_ok_nxt;
            pin_ready_r <= pin_ready_nxt;
        end
    end

    // Internal pacing only while the sample clock runs
    assign gated_tick = i_rate_tick & slow_cfg_r[sctrim_pkg::BIT_CLK_EN];

    sctrim_trig u_trig (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_sel(i_sample_trigger_select),
        .i_rate_tick(gated_tick),
        .i_pin_zero(i_aux_pin_zero),
        .i_pin_one(i_aux_pin_one),
        .o_trigger(o_sample_trigger)
    );

    // Trim codes drive the oscillators straight from the registers
    assign o_cfg.bypass = slow_cfg_r[sctrim_pkg::BIT_BYPASS];
    assign o_cfg.enable = slow_cfg_r[sctrim_pkg::BIT_CLK_EN];
    assign o_cfg.slow_trim = slow_cfg_r[sctrim_pkg::SLOW_TRIM_W-1:0];
    assign o_cfg.fast_trim = fast_cfg_r[sctrim_pkg::FAST_TRIM_W-1:0];
    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_sample_clk = sclk_r;
    assign o_startup_word_ok = word_ok_r;
    assign o_bypass_pin_ready = pin_ready_r;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_slow_write;
        i_reg_wr && i_reg_addr == sctrim_pkg::OFS_SLOW_CFG;
    endsequence

    sequence s_fast_write;
        i_reg_wr && i_reg_addr == sctrim_pkg::OFS_FAST_TRIM;
    endsequence

    sequence s_bypass_on;
        o_cfg.enable && o_cfg.bypass;
    endsequence

    a_reset_values: assert property ($fell(i_sys_rst) |->
        o_cfg.slow_trim == sctrim_pkg::RST_SLOW_TRIM &&
        o_cfg.fast_trim == sctrim_pkg::RST_FAST_TRIM_CODE && !o_cfg.enable && !o_cfg.bypass)
        else $error("Clock config reset values wrong");

    a_slow_trim_update: assert property (s_slow_write |=>
        o_cfg.slow_trim == $past(i_reg_wdata[5:0]) &&
        o_cfg.bypass == $past(i_reg_wdata[8]))
        else $error("Slow trim write not applied");

    a_fast_trim_update: assert property (s_fast_write |=>
        o_cfg.fast_trim == $past(i_reg_wdata[7:0]))
        else $error("Fast trim write not applied");

    a_bypass_source: assert property (s_bypass_on |=>
        o_sample_clk == $past(i_aux_pin_one))
        else $error("Bypass clock not from pin one");

    a_osc_source: assert property (o_cfg.enable && !o_cfg.bypass |=>
        o_sample_clk == $past(i_slow_osc))
        else $error("Sample clock not from oscillator");

    a_clock_stopped: assert property (!o_cfg.enable [*2] |-> !o_sample_clk)
        else $error("Sample clock runs while disabled");

    a_trig_pin_zero: assert property (
        i_sample_trigger_select == sctrim_pkg::TRIG_PIN_ZERO && $rose(i_aux_pin_zero)
        |=> o_sample_trigger)
        else $error("Pin zero edge did not trigger");

    a_trig_reserved: assert property (
        i_sample_trigger_select == sctrim_pkg::TRIG_RESERVED |=> !o_sample_trigger)
        else $error("Reserved selection triggered");

    a_startup_check: assert property (
        pin_trig_sel && $stable(i_sample_trigger_select) &&
        sync_word_r == sctrim_pkg::SYNC_STARTUP_PIN |=> o_startup_word_ok)
        else $error("Startup word status wrong");

    a_read_back: assert property (
        i_reg_rd && i_reg_addr == sctrim_pkg::OFS_FAST_TRIM
        |=> o_reg_rvalid && o_reg_rdata[7:0] == $past(o_cfg.fast_trim))
        else $error("Fast trim read back wrong");

    sequence s_pin_one_edge;
        i_sample_trigger_select == sctrim_pkg::TRIG_PIN_ONE && $rose(i_aux_pin_one);
    endsequence

    a_trig_pin_one: assert property (s_pin_one_edge |=> o_sample_trigger)
        else $error("Pin one edge did not trigger");

    a_trig_internal: assert property (
        i_sample_trigger_select == sctrim_pkg::TRIG_INTERNAL && i_rate_tick && o_cfg.enable
        |=> o_sample_trigger)
        else $error("Internal tick did not trigger");

    a_tick_gated: assert property (
        i_sample_trigger_select == sctrim_pkg::TRIG_INTERNAL && !o_cfg.enable
        |=> !o_sample_trigger)
        else $error("Tick triggered while clock stopped");

    a_startup_internal: assert property (
        !pin_trig_sel && sync_word_r == sctrim_pkg::SYNC_STARTUP_INT
        |=> o_startup_word_ok)
        else $error("Startup word status wrong for internal pacing");

    a_startup_wrong: assert property (
        pin_trig_sel && sync_word_r != sctrim_pkg::SYNC_STARTUP_PIN
        |=> !o_startup_word_ok)
        else $error("Wrong startup word reported good");

    a_pin_ready: assert property (
        {i_pin_one_output_enable, i_pin_one_input_enable} != sctrim_pkg::PIN_ONE_AS_INPUT
        |=> !o_bypass_pin_ready)
        else $error("Pin one reported ready while not an input");

    a_sync_write: assert property (
        i_reg_wr && i_reg_addr == sctrim_pkg::OFS_SYNC_STARTUP
        |=> sync_word_r == $past(i_reg_wdata))
        else $error("Startup word write not stored");

    a_slow_read_back: assert property (
        i_reg_rd && i_reg_addr == sctrim_pkg::OFS_SLOW_CFG
        |=> o_reg_rvalid && o_reg_rdata == $past(slow_cfg_r))
        else $error("Slow clock config read back wrong");

endmodule // sctrim_top

// ### sim/sctrim_top_tb.sv
module sctrim_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] sel = 2'h0;
    logic oe = 1'b0;
    logic ie = 1'b0;
    logic pin0 = 1'b0;
    logic pin1 = 1'b0;
    logic osc = 1'b0;
    logic tick = 1'b0;
    logic [15:0] rdata;
    logic rvalid;
    sctrim_pkg::sctrim_cfg_s cfg;
    logic sclk;
    logic trig;
    logic word_ok;
    logic pin_rdy;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'h0000787C;
    logic [15:0] w;
    logic [15:0] f;
    logic exp_bit;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_trig = 0;

    initial begin
        forever #50 clk = ~clk;
    end

    sctrim_top uut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_sample_trigger_select(sel), .i_pin_one_output_enable(oe),
        .i_pin_one_input_enable(ie), .i_aux_pin_zero(pin0), .i_aux_pin_one(pin1),
        .i_slow_osc(osc), .i_rate_tick(tick), .o_cfg(cfg), .o_sample_clk(sclk),
        .o_sample_trigger(trig), .o_startup_word_ok(word_ok), .o_bypass_pin_ready(pin_rdy));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        step(1);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        addr = a;
        rd = 1'b1;
        step(1);
        rd = 1'b0;
        step(1);
    endtask

    // Read answer scoreboard
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected read", 16'h0000, 16'hFFFF);
            end else begin
                chk("rdata", exp_q.pop_front(), rdata);
            end
        end
        if (trig === 1'b1) begin
            n_trig++;
        end
    end

    initial begin
        #(100 * 5000);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        step(16);
        rst = 1'b0;
        chk("cfg reset", 16'h1298, cfg);
        rd_reg(8'h38, 16'h0000);
        rd_reg(8'h4B, 16'h2612);
        rd_reg(8'h4D, 16'h0098);
        rd_reg(8'h00, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            w = {7'h13, seed[8:7], 1'b0, seed[5:0]};
            f = {8'h00, seed[23:16]};
            if (i < 2) begin
                w[5:0] = i ? 6'h3F : 6'h00;
                f[7:0] = i ? 8'hFF : 8'h00;
            end
            wr_reg(8'h4B, w);
            wr_reg(8'h4D, f);
            chk("cfg", {w[8], w[7], w[5:0], f[7:0]}, cfg);
            rd_reg(8'h4B, w);
            rd_reg(8'h4D, f);
        end
        {oe, ie} = sctrim_pkg::PIN_ONE_AS_INPUT;
        for (int m = 0; m < 3; m++) begin
            w = 16'h2612 | (m > 0 ? 16'h0080 : 16'h0000) | (m == 2 ? 16'h0100 : 16'h0000);
            wr_reg(8'h4B, w);
            for (int k = 0; k < 8; k++) begin
                seed = xs(seed);
                osc = seed[0];
                pin1 = seed[1];
                step(1);
                exp_bit = (m == 0) ? 1'b0 : (m == 1 ? osc : pin1);
                chk("sample clk", {15'h0000, exp_bit}, {15'h0000, sclk});
            end
        end
        pin1 = 1'b0;
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 2; k++) begin
                sel = s[1:0];
                wr_reg(8'h38, k ? 16'h4000 : 16'h0000);
                step(2);
                exp_bit = (s == 1 || s == 2) ? k[0] : ~k[0];
                chk("word ok", {15'h0000, exp_bit}, {15'h0000, word_ok});
            end
        end
        for (int p = 0; p < 4; p++) begin
            {oe, ie} = p[1:0];
            step(2);
            chk("pin ready", {15'h0000, p == 1}, {15'h0000, pin_rdy});
        end
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            wr_reg(8'h38, (s == 1 || s == 2) ? 16'h4000 : 16'h0000);
            step(2);
            n_trig = 0;
            tick = 1'b1;
            step(1);
            tick = 1'b0;
            step(2);
            pin0 = 1'b1;
            step(1);
            pin0 = 1'b0;
            step(2);
            pin1 = 1'b1;
            step(1);
            pin1 = 1'b0;
            step(3);
            chk("triggers", (s == 3) ? 16'h0000 : 16'h0001, 16'(n_trig));
        end
        wr_reg(8'h4B, 16'h2612);
        sel = 2'h0;
        step(2);
        n_trig = 0;
        tick = 1'b1;
        step(1);
        tick = 1'b0;
        step(3);
        chk("triggers disabled", 16'h0000, 16'(n_trig));
        chk("reads left", 16'h0000, 16'(exp_q.size()));
        give_verdict();
    end
endmodule // sctrim_top_tb
